// ==== pkg/dsl_consts.vh ====
// dsl_consts.vh: constants of the serial load port of the dac channel block.
// assumes it is included once per design file by its bare name.
// Notes on behaviour
// - the serial data input is sampled on each rising serial clock edge while chip_select_load is low.
// - a frame holds 24 or 32 bits and both lengths are accepted.
// - the serial data output changes on falling serial clock edges.
// - the serial data output is released whenever chip_select_load is high.
// - while chip_select_load is low, input bits shift into the input shift register.
// - on the rising edge of chip_select_load shifting stops and the frame's command is carried out.
// - with chip_select_load high, a falling async_load_strobe copies all input registers to the dac registers.
// - with async_load_strobe low, each chip_select_load rising edge that queues a frame also copies all registers, after the command.
// - the open-drain fault output pulls low on a transaction error and releases at the next chip_select_load rise.
// - a low async_clear_input returns all channels to zero code, span 0 V to 5 V, and control to defaults.
`ifndef DSL_CONSTS_VH
`define DSL_CONSTS_VH
`define DSL_LEN_SHORT 6'd24
`define DSL_LEN_LONG 6'd32
`define DSL_CMD_WR_IN 4'h0
`define DSL_CMD_WR_IN_UPD 4'h1
`define DSL_CMD_UPD_ONE 4'h2
`define DSL_CMD_UPD_ALL 4'h3
`define DSL_CMD_WR_SPAN 4'h4
`define DSL_CMD_RD_IN 4'h5
`define DSL_CMD_NOP 4'hF
`define DSL_SPAN_RST 4'h0
`define DSL_CODE_RST 16'h0000
`define DSL_FIFO_DEPTH 32
`endif

// ==== hw/dsl_port.v ====
// dsl_port.v: serial command port and dac load control, with its frame fifo.
// assumes serial pins come from outside and are synchronised to mclk here;
// the serial clock must be at most about a quarter of mclk.
// every pin is oversampled, so the port needs no clock of its own; the cost
// is a few mclk of lag between a pin edge and the logic that reacts to it.
// the host must keep chip_select_load high for some mclk between frames so
// that the rise is seen before the next fall.
`include "dsl_consts.vh"

module dsl_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire mclk, // core clock
  input wire rstn, // async reset, low
  input wire [WIDTH-1:0] in_data, // write data
  input wire in_valid, // write request
  output wire in_ready, // room available
  output wire [WIDTH-1:0] out_data, // head word
  output wire out_valid, // head valid
  input wire out_ready // consumer takes head
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wp_q;
  reg [AW:0] rp_q;
  wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = (wp_q != rp_q);
  assign out_data = mem[rp_q[AW-1:0]];
  // pointers carry a wrap bit so full and empty are told apart;
  // this keeps all DEPTH entries usable, at the price of one extra bit
  // per pointer. DEPTH must be a power of two that matches AW.
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wp_q <= {(AW+1){1'b0}};
      rp_q <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) wp_q <= wp_q + 1'b1;
      if (out_valid && out_ready) rp_q <= rp_q + 1'b1;
    end
  end
  // storage has no reset, it is written before it is read
  always @(posedge mclk) begin
    if (in_valid && !full) mem[wp_q[AW-1:0]] <= in_data;
  end
endmodule // dsl_fifo

module dsl_port #(
  parameter CHANNELS = 8,
  parameter CODE_W = 16
) (
  input wire mclk, // core clock, 250 MHz
  input wire rstn, // async reset, low
  input wire chip_select_load, // frame select and load, low active
  input wire sck, // serial clock from host
  input wire sdi, // serial data in
  output reg sdo_o, // serial data out
  output reg sdo_oe_n, // sdo enable, low drives
  input wire async_load_strobe, // dac load strobe, low active
  input wire async_clear_input_n, // clear, low active
  output reg fault_oe_n, // open-drain fault, low pulls pin low
  output reg [CHANNELS*CODE_W-1:0] dac_codes, // dac register contents
  output reg [CHANNELS*4-1:0] dac_spans, // span per channel
  output reg frame_busy // fifo holds unexecuted frames
);
  // two-stage synchronisers on every pin; the host's pins are asynchronous
  // to mclk, so nothing reads the first stage but the second
  reg [1:0] cs_s_q;
  reg [1:0] sck_s_q;
  reg [1:0] sdi_s_q;
  reg [1:0] ld_s_q;
  reg [1:0] clr_s_q;
  // one more stage on the edge-detected pins; reset values match the idle
  // levels so no false edge follows reset
  reg cs_d_q;
  reg sck_d_q;
  reg ld_d_q;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cs_s_q <= 2'h3;
      sck_s_q <= 2'h0;
      sdi_s_q <= 2'h0;
      ld_s_q <= 2'h3;
      clr_s_q <= 2'h3;
      cs_d_q <= 1'b1;
      sck_d_q <= 1'b0;
      ld_d_q <= 1'b1;
    end else begin
      cs_s_q <= {cs_s_q[0], chip_select_load};
      sck_s_q <= {sck_s_q[0], sck};
      sdi_s_q <= {sdi_s_q[0], sdi};
      ld_s_q <= {ld_s_q[0], async_load_strobe};
      clr_s_q <= {clr_s_q[0], async_clear_input_n};
      cs_d_q <= cs_s_q[1];
      sck_d_q <= sck_s_q[1];
      ld_d_q <= ld_s_q[1];
    end
  end
  wire cs = cs_s_q[1];
  wire ld = ld_s_q[1];
  wire clr_n = clr_s_q[1];
  wire sck_rise = sck_s_q[1] & ~sck_d_q;
  wire sck_fall = ~sck_s_q[1] & sck_d_q;
  wire cs_rise = cs & ~cs_d_q;
  wire ld_fall = ~ld & ld_d_q & cs;

  // input shift and bit count; sck ignored while cs is high
  // the count saturates so an overlong frame can never wrap back to a
  // legal length and slip through as a valid command
  reg [31:0] sh_q;
  reg [5:0] cnt_q;
  reg [31:0] rd_q;
  reg [CHANNELS*CODE_W-1:0] in_regs_q;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sh_q <= 32'h00000000;
      cnt_q <= 6'h00;
    end else if (cs) begin
      if (cs_rise) cnt_q <= 6'h00;
    end else if (sck_rise) begin
      sh_q <= {sh_q[30:0], sdi_s_q[1]};
      if (cnt_q != 6'h3F) cnt_q <= cnt_q + 6'h01;
    end
  end

  // frame is closed: legal lengths only, else flag a fault
  // a 32-bit frame leaves its first byte in the upper bits, which are
  // dropped; only the trailing 24 bits are queued
  wire len_ok = (cnt_q == `DSL_LEN_SHORT) || (cnt_q == `DSL_LEN_LONG);
  wire [23:0] frame = sh_q[23:0]; // last 24 bits hold command and data
  wire f_ready;
  wire f_valid;
  wire [24:0] f_data;
  dsl_fifo #(.WIDTH(25), .DEPTH(`DSL_FIFO_DEPTH), .AW(5)) u_fifo (
    .mclk(mclk),
    .rstn(rstn),
    .in_data({~ld, frame}),
    .in_valid(cs_rise && len_ok),
    .in_ready(f_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(1'b1)
  );

  // fault: set on bad length or overflow, released at next cs rise
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) fault_oe_n <= 1'b1;
    else if (cs_rise) fault_oe_n <= len_ok && f_ready;
  end

  // command execution; clear has priority over everything
  // one queued frame is taken per cycle; an asynchronous load that lands
  // in the same cycle still copies every channel, but a dac write by the command wins on its own channel
  wire [3:0] cmd = f_data[23:20];
  wire [3:0] adr = f_data[19:16];
  wire [15:0] val = f_data[15:0];
  integer i;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      in_regs_q <= {CHANNELS{`DSL_CODE_RST}};
      dac_codes <= {CHANNELS{`DSL_CODE_RST}};
      dac_spans <= {CHANNELS{`DSL_SPAN_RST}};
      rd_q <= 32'h00000000;
      frame_busy <= 1'b0;
    end else if (!clr_n) begin
      in_regs_q <= {CHANNELS{`DSL_CODE_RST}};
      dac_codes <= {CHANNELS{`DSL_CODE_RST}};
      dac_spans <= {CHANNELS{`DSL_SPAN_RST}};
      frame_busy <= 1'b0;
    end else begin
      frame_busy <= f_valid;
      if (ld_fall) dac_codes <= in_regs_q;
      if (f_valid) begin
        for (i = 0; i < CHANNELS; i = i + 1) begin
          if (adr == i[3:0]) begin
            case (cmd)
              `DSL_CMD_WR_IN: in_regs_q[i*CODE_W +: CODE_W] <= val;
              `DSL_CMD_WR_IN_UPD: begin
                in_regs_q[i*CODE_W +: CODE_W] <= val;
                dac_codes[i*CODE_W +: CODE_W] <= val;
              end
              `DSL_CMD_UPD_ONE:
                dac_codes[i*CODE_W +: CODE_W] <= in_regs_q[i*CODE_W +: CODE_W];
              `DSL_CMD_WR_SPAN: dac_spans[i*4 +: 4] <= val[3:0];
              `DSL_CMD_RD_IN:
                rd_q <= {16'h0000, in_regs_q[i*CODE_W +: CODE_W]};
              default: ;
            endcase
          end
        end
        // load-all after the command: strobe held low or update-all command
        if (f_data[24] || cmd == `DSL_CMD_UPD_ALL) begin
          dac_codes <= in_regs_q;
          // channels beyond the last one must not alias onto a real one
          if (!adr[3] && (cmd == `DSL_CMD_WR_IN_UPD ||
              cmd == `DSL_CMD_WR_IN))
            dac_codes[adr[2:0]*CODE_W +: CODE_W] <= val;
        end
      end
    end
  end

  // readback shifts out msb first on falling edges; released while cs high
  // the first bit is presented before the first clock so the host can take
  // it on the first rising edge of the frame
  reg [31:0] out_sh_q;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      out_sh_q <= 32'h00000000;
      sdo_o <= 1'b0;
      sdo_oe_n <= 1'b1;
    end else if (cs) begin
      sdo_oe_n <= 1'b1;
      out_sh_q <= rd_q;
      sdo_o <= rd_q[31];
    end else begin
      sdo_oe_n <= 1'b0;
      if (sck_fall) begin
        sdo_o <= out_sh_q[30];
        out_sh_q <= {out_sh_q[30:0], 1'b0};
      end
    end
  end
endmodule // dsl_port

// ==== tb/dsl_port_sva.sv ====
// dsl_port_sva.sv: pin-level checks of the serial load port.
// assumes 2-ff input sync inside, so figures allow a few mclk of lag.
module dsl_port_sva #(parameter int CHANNELS = 8, parameter int CODE_W = 16) (
  input wire logic mclk, // clock
  input wire logic rstn, // reset, low
  input wire logic chip_select_load, // frame select
  input wire logic sck, // serial clock
  input wire logic sdo_o, // serial out
  input wire logic async_load_strobe, // load strobe
  input wire logic async_clear_input_n, // clear
  input wire logic sdo_oe_n, // sdo enable
  input wire logic fault_oe_n, // fault pull
  input wire logic [CHANNELS*CODE_W-1:0] dac_codes, // codes
  input wire logic [CHANNELS*4-1:0] dac_spans, // spans
  input wire logic frame_busy // fifo busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // windows are longer than the sync lag so a late edge never trips them
  a_sdo_release: assert property (chip_select_load [*5] |-> sdo_oe_n)
    else $error("sdo driven while deselected");
  a_sdo_drive: assert property (!chip_select_load [*5] |-> !sdo_oe_n)
    else $error("sdo not driven in frame");
  a_sdo_steady: assert property ((sck && !sdo_oe_n) [*5] |=> $stable(sdo_o))
    else $error("sdo moved with clock high");
  a_codes_idle: assert property ((chip_select_load && async_load_strobe
    && async_clear_input_n && !frame_busy) [*8] |-> $stable(dac_codes))
    else $error("codes moved while idle");
  a_spans_frame: assert property ((!chip_select_load && !frame_busy) [*8]
    |-> $stable(dac_spans)) else $error("spans moved mid frame");
  a_clear_zero: assert property (!async_clear_input_n [*5]
    |-> dac_codes == '0 && dac_spans == '0) else $error("clear ignored");
  a_fault_hold: assert property ((chip_select_load && !fault_oe_n) [*6]
    |=> !fault_oe_n) else $error("fault dropped early");
  a_fault_set: assert property ($fell(fault_oe_n) |-> chip_select_load)
    else $error("fault set mid frame");
  a_fault_clear: assert property ($rose(fault_oe_n)
    |-> $past(chip_select_load, 2)) else $error("fault released mid frame");
  cover property ($fell(fault_oe_n));
  cover property (!async_load_strobe && $rose(chip_select_load));
  cover property ($changed(dac_spans));
endmodule // dsl_port_sva

// ==== tb/dsl_host.sv ====
// dsl_host.sv: behavioural host that shifts frames into the serial port.
// assumes a 4 ns mclk; sck runs at 48 ns only inside frames.
module dsl_host (
  input wire logic mclk, // paces the link
  output logic cs_n, // frame select
  output logic sck, // serial clock, idle low
  output logic sdi, // serial data to port
  input wire logic sdo // serial data back
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rd;
  // msb first; sdi flips once deselected so stale data never matches
  task automatic send(input logic [31:0] w, input int n);
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = w[i];
      repeat (6) @(negedge mclk);
      sck = 1'b1;
      rd = {rd[30:0], sdo};
      repeat (6) @(negedge mclk);
      sck = 1'b0;
    end
    repeat (3) @(negedge mclk);
    cs_n = 1'b1;
    sdi = ~sdi;
    repeat (8) @(negedge mclk);
  endtask
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
    rd = '0;
  end
endmodule // dsl_host

// ==== tb/dsl_port_tb.sv ====
// dsl_port_tb.sv: self-checking bench for the serial load port.
// assumes the host model paces frames; the checker is bound below.
module dsl_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rstn = 1'b0;
  logic async_load_strobe = 1'b1, async_clear_input_n = 1'b1;
  logic chip_select_load, sck, sdi, sdo_o, sdo_oe_n, fault_oe_n, frame_busy;
  logic [127:0] dac_codes;
  logic [31:0] dac_spans;
  logic [15:0] exp_code [8] = '{default: 16'h0};
  logic [15:0] d;
  int n_errors = 0, cmp_count = 0, ch;
  always #2 mclk = ~mclk;
  dsl_port u_dut (.*);
  dsl_host u_host (.mclk(mclk), .cs_n(chip_select_load), .sck(sck),
    .sdi(sdi), .sdo(sdo_oe_n ? 1'bz : sdo_o));
  task automatic chk(input string what, input logic [159:0] seen, exp_v);
    cmp_count++;
    if (seen !== exp_v) begin
      n_errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp_v, seen);
    end
  endtask
  task automatic test_done;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one frame, then a bounded wait for the fifo to drain
  task automatic fr(input logic [31:0] w, input int n);
    int k;
    u_host.send(w, n);
    for (k = 0; k < 60 && frame_busy !== 1'b0; k++) @(negedge mclk);
    if (k == 60) begin
      n_errors++;
      test_done();
    end
    repeat (4) @(negedge mclk);
    chk("busy", frame_busy, 1'b0);
  endtask
  initial begin
    void'($urandom(32'hA01D));
    repeat (12) @(negedge mclk);
    rstn = 1'b1;
    repeat (3) @(negedge mclk);
    chk("codes", dac_codes, 160'h0);
    chk("fault", fault_oe_n, 1'b1);
    for (int i = 0; i < 12; i++) begin
      ch = (i == 0) ? 7 : int'($urandom % 8);
      d = (i == 0) ? 16'hFFFF : 16'($urandom);
      fr({8'h5A, 4'h1, 4'(ch), d}, i[0] ? 32 : 24);
      exp_code[ch] = d;
      chk("update", dac_codes[ch*16 +: 16], exp_code[ch]);
    end
    fr({8'h0, 4'h0, 4'h3, 16'h1234}, 24);
    chk("held", dac_codes[63:48], exp_code[3]);
    async_load_strobe = 1'b0;
    repeat (8) @(negedge mclk);
    chk("strobe", dac_codes[63:48], 16'h1234);
    fr({8'h0, 4'h0, 4'h5, 16'hBEEF}, 32);
    chk("cs_load", dac_codes[95:80], 16'hBEEF);
    async_load_strobe = 1'b1;
    fr({8'h0, 4'h4, 4'h2, 16'h0003}, 24);
    chk("span", dac_spans[11:8], 4'h3);
    fr({8'h0, 4'h5, 4'h5, 16'h0}, 24);
    fr({8'h0, 4'hF, 4'h0, 16'h0}, 32);
    chk("readback", u_host.rd, 32'h0000BEEF);
    u_host.send(32'h0, 23);
    chk("fault", fault_oe_n, 1'b0);
    fr({8'h0, 4'hF, 4'h0, 16'h0}, 24);
    chk("release", fault_oe_n, 1'b1);
    async_clear_input_n = 1'b0;
    repeat (8) @(negedge mclk);
    chk("clear", {dac_codes, dac_spans}, 160'h0);
    async_clear_input_n = 1'b1;
    test_done();
  end
endmodule // dsl_port_tb
bind dsl_port dsl_port_sva #(.CHANNELS(CHANNELS), .CODE_W(CODE_W))
  u_sva (.*);
